// ### scrc_ctrl.sv
// Standby and reset controller: clock gates, bus pin overrides, fetch start.
// Assumes i_rstn is the filtered reset pin; CPU bus signals are on i_clk_sys.
`timescale 1ns/10ps
module scrc_ctrl
	import scrc_pkg::*;
#(
	parameter int SETTLE_CY = SCRC_SETTLE_CY
) (
	// Clock and reset
	input  wire logic                   i_clk_sys,
	input  wire logic                   i_rstn,
	input  wire logic                   i_ce,
	// Configuration and CPU requests
	input  wire logic [1:0]             i_clk_src,
	input  wire logic [1:0]             i_stby_sel,
	input  wire logic                   i_halt_exec,
	input  wire logic                   i_system_clock_out_pin_inhibit,
	input  wire logic                   i_int_req,
	// Pins from outside
	input  wire logic                   i_nmi_pin,
	input  wire logic                   i_bus_hold_request,
	// CPU bus in ordinary operation
	input  wire logic [SCRC_ADDR_W-1:0] i_cpu_addr,
	input  wire logic [SCRC_ADDR_W-1:0] i_cpu_pc,
	input  wire logic [SCRC_DATA_W-1:0] i_cpu_dout,
	input  wire logic                   i_cpu_data_oe,
	input  wire logic [SCRC_PORT_W-1:0] i_port_out,
	input  wire logic [SCRC_PORT_W-1:0] i_port_oe,
	input  wire logic [SCRC_CS_W-1:0]   i_chip_select_lines,
	input  wire logic                   i_memory_read_strobe,
	input  wire logic                   i_io_read_strobe,
	input  wire logic                   i_io_write_strobe,
	input  wire logic                   i_refresh_request_out,
	input  wire logic                   i_lower_column_strobe,
	input  wire logic                   i_upper_column_strobe,
	input  wire logic                   i_cbr_refresh,
	input  wire logic                   i_watchdog_timeout_out,
	// Clock controls
	output logic                        o_osc_en,
	output logic                        o_pll_en,
	output logic                        o_periph_clk_en,
	output logic                        o_cpu_clk_en,
	output logic                        o_system_clock_out_pin,
	// Program start
	output logic                        o_cpu_start,
	output logic                        o_fetch_req,
	// Pins
	output logic [SCRC_ADDR_W-1:0]      o_addr,
	output logic [SCRC_DATA_W-1:0]      o_data,
	output logic                        o_data_oe,
	output logic [SCRC_PORT_W-1:0]      o_port,
	output logic [SCRC_PORT_W-1:0]      o_port_oe,
	output logic [SCRC_CS_W-1:0]        o_chip_select_lines_n,
	output logic                        o_strobe_oe,
	output logic                        o_memory_read_strobe_n,
	output logic                        o_io_read_strobe_n,
	output logic                        o_io_write_strobe_n,
	output logic                        o_refresh_request_out_n,
	output logic                        o_lower_column_strobe_n,
	output logic                        o_upper_column_strobe_n,
	output logic                        o_self_refresh,
	output logic                        o_bus_hold_grant_n,
	output logic                        o_watchdog_timeout_out,
	output logic                        o_mode_stop
);
	scrc_state_t st_q;
	scrc_state_t st_d;
	logic        nmi_s;
	logic        hold_s;
	logic        nmi_prev_q;
	logic        nmi_prev_d;
	logic        wake;
	logic        settle_start;
	logic        settle_done;
	logic [5:0]  rcnt_q;
	logic [5:0]  rcnt_d;
	logic        started_q;
	logic        started_d;
	logic        clkdiv_q;
	logic        clkdiv_d;
	logic        pll_src;
	logic        res_src;
	logic [1:0]  hold_sync_q;
	logic [1:0]  hold_sync_d;

	scrc_sync #(.W(1)) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_ce      (i_ce),
		.i_async   (i_nmi_pin),
		.o_sync    (nmi_s)
	);

	// Hold path has no reset: a master may take the bus during reset
	always_comb begin
		hold_sync_d = i_ce ? {hold_sync_q[0], i_bus_hold_request}
			: hold_sync_q;
	end

	always_ff @(posedge i_clk_sys) begin
		hold_sync_q <= hold_sync_d;
	end

	assign hold_s = hold_sync_q[1];

	scrc_wdt #(.SETTLE_CY(SETTLE_CY)) u_wdt (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_ce      (i_ce),
		.i_clear   ((st_q == SCRC_STOP) && !settle_start),
		.i_start   (settle_start),
		.o_done    (settle_done)
	);

	assign pll_src = (i_clk_src != SCRC_SRC_DIRECT);
	assign res_src = (i_clk_src == SCRC_SRC_PLL_RES);
	// NMI is a falling-edge pin; interrupts are on-clock levels
	assign wake = (nmi_prev_q && !nmi_s) || i_int_req;
	assign settle_start = (st_q == SCRC_STOP) && wake && pll_src;

	// Standby state machine
	always_comb begin
		st_d       = st_q;
		nmi_prev_d = nmi_prev_q;
		if (i_ce) begin
			nmi_prev_d = nmi_s;
			unique case (st_q)
				SCRC_RUN: begin
					if (i_halt_exec) begin
						unique case (i_stby_sel)
							SCRC_SEL_IDLE: st_d = SCRC_IDLE;
							SCRC_SEL_STOP: st_d = SCRC_STOP;
							default:       st_d = SCRC_HALT;
						endcase
					end
				end
				SCRC_HALT, SCRC_IDLE: begin
					if (wake)
						st_d = SCRC_RUN;
				end
				SCRC_STOP: begin
					if (wake)
						st_d = pll_src ? SCRC_SETTLE : SCRC_RUN;
				end
				SCRC_SETTLE: begin
					if (settle_done)
						st_d = SCRC_RUN;
				end
				default: st_d = SCRC_RUN;
			endcase
		end
	end

	// Reset fetch counter, program start and clock output divider
	always_comb begin
		rcnt_d    = rcnt_q;
		started_d = started_q;
		clkdiv_d  = clkdiv_q;
		if (i_ce) begin
			// If-else form lets a divider without reset leave X
			if (clkdiv_q)
				clkdiv_d = 1'b0;
			else
				clkdiv_d = 1'b1;
			if (rcnt_q != SCRC_RST_CNT_W)
				rcnt_d = rcnt_q + 6'h01;
			else if (!hold_s)
				started_d = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			st_q       <= SCRC_RUN;
			nmi_prev_q <= 1'b0;
			rcnt_q     <= 6'h00;
			started_q  <= 1'b0;
		end else begin
			st_q       <= st_d;
			nmi_prev_q <= nmi_prev_d;
			rcnt_q     <= rcnt_d;
			started_q  <= started_d;
		end
	end

	// Clock output and hold answer run through reset: no reset here
	always_ff @(posedge i_clk_sys) begin
		clkdiv_q <= clkdiv_d;
		if (i_ce) begin
			o_system_clock_out_pin <= clkdiv_d && !i_system_clock_out_pin_inhibit
				&& (st_d != SCRC_STOP) && (st_d != SCRC_SETTLE);
			o_bus_hold_grant_n     <= !hold_s;
			o_strobe_oe            <= !hold_s;
		end
	end

	// Output registers; reset values are the defined reset pin state
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_osc_en                <= 1'b1;
			o_pll_en                <= 1'b1;
			o_periph_clk_en         <= 1'b1;
			o_cpu_clk_en            <= 1'b0;
			o_cpu_start             <= 1'b0;
			o_fetch_req             <= 1'b0;
			o_addr                  <= '0;
			o_data                  <= '0;
			o_data_oe               <= 1'b0;
			o_port                  <= '0;
			o_port_oe               <= '0;
			o_chip_select_lines_n   <= '1;
			o_memory_read_strobe_n  <= 1'b1;
			o_io_read_strobe_n      <= 1'b1;
			o_io_write_strobe_n     <= 1'b1;
			o_refresh_request_out_n <= 1'b1;
			o_lower_column_strobe_n <= 1'b1;
			o_upper_column_strobe_n <= 1'b1;
			o_self_refresh          <= 1'b0;
			o_watchdog_timeout_out  <= 1'b0;
			o_mode_stop             <= 1'b0;
		end else if (i_ce) begin
			// Clock gating per source and standby mode
			o_osc_en <= res_src && (st_d != SCRC_STOP);
			o_pll_en <= pll_src && (st_d != SCRC_STOP);
			o_periph_clk_en <= (st_d == SCRC_RUN) || (st_d == SCRC_HALT);
			o_cpu_clk_en <= started_d && (st_d == SCRC_RUN);
			o_cpu_start <= started_d && !started_q;
			o_fetch_req <= started_d && !started_q;
			o_mode_stop <= (st_d == SCRC_STOP);
			o_watchdog_timeout_out <= i_watchdog_timeout_out;
			o_port    <= i_port_out;
			o_port_oe <= started_q ? i_port_oe : '0;
			// Pins follow the next state so they park with the clocks
			if (hold_s) begin
				// Bus released to the hold master
				o_data_oe <= 1'b0;
			end else if (!started_q) begin
				o_data_oe <= 1'b0;
			end else if (st_d != SCRC_RUN) begin
				o_addr                 <= i_cpu_pc;
				o_data_oe              <= 1'b0;
				o_chip_select_lines_n  <= '1;
				o_memory_read_strobe_n <= 1'b1;
				o_io_read_strobe_n     <= 1'b1;
				o_io_write_strobe_n    <= 1'b1;
				if (st_d == SCRC_HALT) begin
					// Refresh keeps running in HALT
					o_self_refresh          <= 1'b0;
					o_refresh_request_out_n <= !(i_cbr_refresh && i_refresh_request_out);
					o_lower_column_strobe_n <= !(i_cbr_refresh && i_lower_column_strobe);
					o_upper_column_strobe_n <= !(i_cbr_refresh && i_upper_column_strobe);
				end else begin
					o_self_refresh          <= 1'b1;
					o_refresh_request_out_n <= 1'b0;
					o_lower_column_strobe_n <= 1'b0;
					o_upper_column_strobe_n <= 1'b0;
				end
			end else begin
				o_addr                  <= i_cpu_addr;
				o_data                  <= i_cpu_dout;
				o_data_oe               <= i_cpu_data_oe;
				o_chip_select_lines_n   <= ~i_chip_select_lines;
				o_memory_read_strobe_n  <= !(i_memory_read_strobe || o_fetch_req);
				o_io_read_strobe_n      <= !i_io_read_strobe;
				o_io_write_strobe_n     <= !i_io_write_strobe;
				o_refresh_request_out_n <= !i_refresh_request_out;
				o_lower_column_strobe_n <= !i_lower_column_strobe;
				o_upper_column_strobe_n <= !i_upper_column_strobe;
				o_self_refresh          <= 1'b0;
			end
		end
	end
endmodule // scrc_ctrl

// ### scrc_pkg.sv
// Constants for the standby clock and reset controller.
// Assumes one 25 MHz system clock and pins sampled by the top module.
// Operation
// - STOP halts oscillator and PLL, so all internal clocks stop.
// - With PLL source, PLL output stops together with the oscillator in STOP.
// - Leaving STOP with PLL source waits oscillation settling before clocking.
// - Direct source leaves STOP with no PLL lock-up wait.
// - PLL resonator: HALT stops CPU; IDLE stops CPU, peripherals; STOP all.
// - External clock keeps oscillator off; direct mode keeps PLL off too; reset still sets o_osc_en and o_pll_en high.
// - All internal state is kept through HALT, IDLE and STOP; the code clears the watchdog settling counter in STOP.
// - Standby holds I/O, drives PC on address, floats data, strobes high.
// - HALT keeps DRAM strobes high except refresh; IDLE, STOP self-refresh.
// - Clock output keeps running in HALT and IDLE unless software inhibits it; it stops in STOP.
// - 30 cycles after the reset rising edge the CPU begins running its program.
// - Every output pin but clock output, hold grant and strobe enable holds its reset state for the whole reset.
// - After 30 cycles past reset release with no hold request, start fetch read.
// - Hold request during reset is granted, pins as for ordinary hold.
// - Clock output keeps running while reset is asserted.
// - Reset: address undefined, data and ports float, strobes high, watchdog low.
// - Halt instruction enters HALT, IDLE or STOP as standby control selects.
// - After STOP, watchdog restarts at zero, times settling, no output pulse.
// - Release from IDLE resumes at once with no settling wait.

package scrc_pkg;

	typedef enum logic [4:0] {
		SCRC_RUN    = 5'h01,
		SCRC_HALT   = 5'h02,
		SCRC_IDLE   = 5'h04,
		SCRC_STOP   = 5'h08,
		SCRC_SETTLE = 5'h10
	} scrc_state_t;

	// Standby selection codes driven by the CPU's standby control
	localparam logic [1:0] SCRC_SEL_HALT = 2'h0;
	localparam logic [1:0] SCRC_SEL_IDLE = 2'h1;
	localparam logic [1:0] SCRC_SEL_STOP = 2'h2;

	// Clock source selection
	localparam logic [1:0] SCRC_SRC_PLL_RES = 2'h0;
	localparam logic [1:0] SCRC_SRC_PLL_EXT = 2'h1;
	localparam logic [1:0] SCRC_SRC_DIRECT  = 2'h2;

	localparam int SCRC_CLK_MHZ      = 25;
	localparam int SCRC_RST_FETCH_CY = 30;
	localparam logic [5:0] SCRC_RST_CNT_W = 6'h1E;

	// Settling time in microseconds, as a cycle count at the system clock
	localparam int SCRC_SETTLE_US = 10;
	localparam int SCRC_SETTLE_CY = SCRC_SETTLE_US * SCRC_CLK_MHZ;
	localparam int SCRC_WDT_W     = 16;

	localparam int SCRC_ADDR_W = 24;
	localparam int SCRC_DATA_W = 16;
	localparam int SCRC_PORT_W = 10;
	localparam int SCRC_CS_W   = 4;

endpackage

// ### scrc_sync.sv
// Two-stage synchroniser for pin inputs.
// Assumes the input is asynchronous to i_clk_sys.
`timescale 1ns/10ps
module scrc_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_rstn,
	input  wire logic         i_ce,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = i_ce ? i_async : meta_q;
		sync_d = i_ce ? meta_q : sync_q;
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign o_sync = sync_q;
endmodule // scrc_sync

// ### scrc_wdt.sv
// Settling-time counter of the watchdog, used on release from STOP.
// Assumes the top raises i_start for one cycle when STOP is released with a PLL source.
`timescale 1ns/10ps
module scrc_wdt
	import scrc_pkg::*;
#(
	parameter int SETTLE_CY = SCRC_SETTLE_CY
) (
	input  wire logic i_clk_sys,
	input  wire logic i_rstn,
	input  wire logic i_ce,
	// Control
	input  wire logic i_clear,
	input  wire logic i_start,
	// Status
	output logic      o_done
);
	logic [SCRC_WDT_W-1:0] cnt_q;
	logic [SCRC_WDT_W-1:0] cnt_d;
	logic                  run_q;
	logic                  run_d;
	logic                  done_q;
	logic                  done_d;

	localparam logic [SCRC_WDT_W-1:0] LAST = SCRC_WDT_W'(SETTLE_CY - 1);

	always_comb begin
		cnt_d  = cnt_q;
		run_d  = run_q;
		done_d = 1'b0;
		if (i_ce) begin
			if (i_clear) begin
				cnt_d = '0;
				run_d = 1'b0;
			end else if (i_start) begin
				cnt_d = '0;
				run_d = 1'b1;
			end else if (run_q) begin
				if (cnt_q == LAST) begin
					run_d  = 1'b0;
					done_d = 1'b1;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q  <= '0;
			run_q  <= 1'b0;
			done_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			run_q  <= run_d;
			done_q <= done_d;
		end
	end

	assign o_done = done_q;
endmodule // scrc_wdt

// ### scrc_assertions.sv
// Checker for scrc_ctrl: standby entry, wake latency, reset fetch, hold.
// Assumes i_ce high, a steady PC while parked, source changed in reset.
`timescale 1ns/10ps
module scrc_assertions
	import scrc_pkg::*;
#(
	parameter int SETTLE_CY = SCRC_SETTLE_CY
) (
	input wire logic                   i_clk_sys,
	input wire logic                   i_rstn,
	input wire logic                   i_ce,
	input wire logic [1:0]             i_clk_src,
	input wire logic [1:0]             i_stby_sel,
	input wire logic                   i_halt_exec,
	input wire logic                   i_system_clock_out_pin_inhibit,
	input wire logic                   i_int_req,
	input wire logic                   i_bus_hold_request,
	input wire logic [SCRC_ADDR_W-1:0] i_cpu_pc,
	input wire logic                   o_osc_en,
	input wire logic                   o_pll_en,
	input wire logic                   o_periph_clk_en,
	input wire logic                   o_cpu_clk_en,
	input wire logic                   o_system_clock_out_pin,
	input wire logic                   o_cpu_start,
	input wire logic                   o_fetch_req,
	input wire logic [SCRC_ADDR_W-1:0] o_addr,
	input wire logic                   o_data_oe,
	input wire logic [SCRC_CS_W-1:0]   o_chip_select_lines_n,
	input wire logic                   o_strobe_oe,
	input wire logic                   o_memory_read_strobe_n,
	input wire logic                   o_self_refresh,
	input wire logic                   o_bus_hold_grant_n,
	input wire logic                   o_watchdog_timeout_out,
	input wire logic                   o_mode_stop
);
	// Cycles since reset release, saturating
	logic [7:0] rel_cnt_q;
	logic [7:0] rel_cnt_d;

	always_comb begin
		rel_cnt_d = (rel_cnt_q == 8'hFF) ? rel_cnt_q : rel_cnt_q + 8'h01;
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn)
			rel_cnt_q <= 8'h00;
		else
			rel_cnt_q <= rel_cnt_d;
	end

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);

	sequence s_take(logic [1:0] sel);
		i_ce && o_cpu_clk_en && i_halt_exec && i_stby_sel == sel;
	endsequence
	// Wake request three cycles after the halt was taken
	sequence s_wake;
		##1 !i_int_req [*2] ##1 i_int_req;
	endsequence

	property p_stop;
		s_take(SCRC_SEL_STOP) |=> !o_osc_en && !o_pll_en
			&& !o_periph_clk_en && !o_cpu_clk_en && o_mode_stop;
	endproperty
	a_stop: assert property (p_stop) else $error("stop gating wrong");

	property p_idle;
		s_take(SCRC_SEL_IDLE) |=> o_osc_en == (i_clk_src == SCRC_SRC_PLL_RES)
			&& o_pll_en == (i_clk_src != SCRC_SRC_DIRECT)
			&& !o_periph_clk_en && !o_cpu_clk_en && o_self_refresh;
	endproperty
	a_idle: assert property (p_idle) else $error("idle gating wrong");

	property p_halt;
		s_take(SCRC_SEL_HALT) |=> o_periph_clk_en && !o_cpu_clk_en
			&& !o_data_oe && o_addr == i_cpu_pc && &o_chip_select_lines_n
			&& o_memory_read_strobe_n
			##1 ($changed(o_system_clock_out_pin) || i_system_clock_out_pin_inhibit);
	endproperty
	a_halt: assert property (p_halt) else $error("halt pins wrong");

	property p_direct;
		i_clk_src == SCRC_SRC_DIRECT && o_cpu_clk_en |-> !o_osc_en && !o_pll_en;
	endproperty
	a_direct: assert property (p_direct) else $error("direct gen on");

	property p_idle_wake;
		s_take(SCRC_SEL_IDLE) ##0 s_wake |=> o_cpu_clk_en;
	endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle wake slow");

	property p_stop_pll;
		s_take(SCRC_SEL_STOP) ##0 (i_clk_src != SCRC_SRC_DIRECT) ##0 s_wake
			|=> (!o_cpu_clk_en && !o_watchdog_timeout_out) [*4]
			##[1:3] o_cpu_clk_en;
	endproperty
	a_stop_pll: assert property (p_stop_pll) else $error("settle wrong");

	property p_stop_dir;
		s_take(SCRC_SEL_STOP) ##0 (i_clk_src == SCRC_SRC_DIRECT) ##0 s_wake
			|=> o_cpu_clk_en;
	endproperty
	a_stop_dir: assert property (p_stop_dir) else $error("direct wait");

	property p_hold;
		(i_ce && i_bus_hold_request && !o_mode_stop) [*4]
			|-> !o_bus_hold_grant_n && !o_strobe_oe;
	endproperty
	a_hold: assert property (p_hold) else $error("hold not granted");

	property p_fetch_win;
		$rose(i_rstn) ##0 !i_bus_hold_request |-> ##[28:32] o_fetch_req;
	endproperty
	a_fetch_win: assert property (p_fetch_win) else $error("no fetch");

	property p_fetch_at;
		o_fetch_req |-> rel_cnt_q >= 8'h1D && rel_cnt_q <= 8'h20
			&& o_cpu_start && o_cpu_clk_en;
	endproperty
	a_fetch_at: assert property (p_fetch_at) else $error("fetch timing");
endmodule // scrc_assertions

bind scrc_ctrl scrc_assertions #(.SETTLE_CY(SETTLE_CY)) u_scrc_chk (.*);

// ### scrc_board_model.sv
// Board side: reset circuit and a bus master that may request hold.
// Assumes the bench calls its tasks; pins move at the falling edge.
`timescale 1ns/10ps
module scrc_board_model (
	input  wire logic i_clk_sys,
	output logic      o_rstn,
	output logic      o_hold_req
);
	// Power-on reset, hold kept quiet meanwhile
	initial begin
		o_rstn = 1'b0;
		o_hold_req = 1'b0;
		repeat (3) @(negedge i_clk_sys);
		o_rstn <= 1'b1;
	end

	task automatic set_reset(input logic v);
		@(negedge i_clk_sys);
		o_rstn <= v;
	endtask

	task automatic set_hold(input logic v);
		@(negedge i_clk_sys);
		o_hold_req <= v;
	endtask
endmodule // scrc_board_model

// ### test_standby_clock_reset_control.sv
// Self-checking bench for scrc_ctrl with a board model on the far side.
// Assumes SETTLE_CY shortened to 4; CPU bus inputs busy while running.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module test_standby_clock_reset_control;
	import scrc_pkg::*;
	localparam int SETTLE = 4;
	logic i_clk_sys, i_rstn, i_ce, i_halt_exec, i_system_clock_out_pin_inhibit, i_int_req;
	logic [1:0] i_clk_src, i_stby_sel;
	logic i_nmi_pin, i_bus_hold_request, i_cpu_data_oe, i_memory_read_strobe;
	logic i_io_read_strobe, i_io_write_strobe, i_refresh_request_out;
	logic i_lower_column_strobe, i_upper_column_strobe, i_cbr_refresh;
	logic i_watchdog_timeout_out, o_osc_en, o_pll_en, o_periph_clk_en;
	logic [SCRC_ADDR_W-1:0] i_cpu_addr, i_cpu_pc, o_addr;
	logic [SCRC_DATA_W-1:0] i_cpu_dout, o_data;
	logic [SCRC_PORT_W-1:0] i_port_out, i_port_oe, o_port, o_port_oe;
	logic [SCRC_CS_W-1:0] i_chip_select_lines, o_chip_select_lines_n;
	logic o_cpu_clk_en, o_system_clock_out_pin, o_cpu_start, o_fetch_req;
	logic o_data_oe, o_strobe_oe, o_memory_read_strobe_n, o_io_read_strobe_n;
	logic o_io_write_strobe_n, o_refresh_request_out_n, o_self_refresh;
	logic o_lower_column_strobe_n, o_upper_column_strobe_n, o_mode_stop;
	logic o_bus_hold_grant_n, o_watchdog_timeout_out;
	int miscompares, checked;

	scrc_ctrl #(.SETTLE_CY(SETTLE)) u_dut (.*);
	scrc_board_model u_board (
		.i_clk_sys  (i_clk_sys),
		.o_rstn     (i_rstn),
		.o_hold_req (i_bus_hold_request)
	);

	initial begin
		i_clk_sys = 1'b0;
		forever #20 i_clk_sys = ~i_clk_sys;
	end

	task automatic final_report;
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Reset with a new clock source, pins checked, then time the fetch
	task automatic t_fetch(input logic [1:0] src);
		int n;
		logic c;
		u_board.set_reset(1'b0);
		i_clk_src = src;
		// First reset edge may restart a clock output parked in STOP
		@(negedge i_clk_sys);
		c = o_system_clock_out_pin;
		repeat (3) begin
			@(negedge i_clk_sys);
			`CHK(o_system_clock_out_pin, ~c)
			c = o_system_clock_out_pin;
			`CHK({o_chip_select_lines_n, o_memory_read_strobe_n, o_io_read_strobe_n, o_io_write_strobe_n, o_bus_hold_grant_n, o_strobe_oe}, 9'h1FF)
			`CHK({o_data_oe, o_port_oe, o_watchdog_timeout_out, o_cpu_clk_en}, 13'h0000)
		end
		u_board.set_reset(1'b1);
		n = 0;
		while (o_fetch_req !== 1'b1 && n < 60) begin
			@(negedge i_clk_sys);
			n++;
		end
		`CHK(n inside {30, 31}, 1'b1)
		`CHK({o_cpu_start, o_cpu_clk_en}, 2'b11)
	endtask

	// Enter one standby mode, check gating and pins, wake by interrupt
	task automatic t_mode(input logic [1:0] sel);
		int n;
		logic c;
		logic [3:0] exp;
		exp = {i_clk_src == SCRC_SRC_PLL_RES && sel != SCRC_SEL_STOP,
			i_clk_src != SCRC_SRC_DIRECT && sel != SCRC_SEL_STOP,
			sel == SCRC_SEL_HALT, 1'b0};
		@(negedge i_clk_sys);
		i_stby_sel = sel;
		i_halt_exec = 1'b1;
		@(negedge i_clk_sys);
		i_halt_exec = 1'b0;
		`CHK({o_osc_en, o_pll_en, o_periph_clk_en, o_cpu_clk_en}, exp)
		`CHK({o_addr, o_data_oe, o_chip_select_lines_n, o_memory_read_strobe_n}, {i_cpu_pc, 6'h1F})
		`CHK({o_self_refresh, o_mode_stop}, {sel != SCRC_SEL_HALT, sel == SCRC_SEL_STOP})
		`CHK({o_refresh_request_out_n, o_lower_column_strobe_n, o_upper_column_strobe_n}, {3{sel == SCRC_SEL_HALT}})
		`CHK({o_port, o_port_oe}, {i_port_out, i_port_oe})
		c = o_system_clock_out_pin;
		@(negedge i_clk_sys);
		if (sel != SCRC_SEL_STOP)
			`CHK(o_system_clock_out_pin, ~c)
		@(negedge i_clk_sys);
		i_int_req = 1'b1;
		n = 0;
		while (o_cpu_clk_en !== 1'b1 && n < 40) begin
			@(negedge i_clk_sys);
			n++;
			`CHK(o_watchdog_timeout_out, 1'b0)
		end
		i_int_req = 1'b0;
		exp = (sel == SCRC_SEL_STOP && i_clk_src != SCRC_SRC_DIRECT) ? 4'h6 : 4'h1;
		`CHK(n, int'(exp))
	endtask

	task automatic t_hold;
		i_system_clock_out_pin_inhibit = 1'b1;
		repeat (2) begin
			@(negedge i_clk_sys);
			`CHK(o_system_clock_out_pin, 1'b0)
		end
		i_system_clock_out_pin_inhibit = 1'b0;
		u_board.set_hold(1'b1);
		repeat (4) @(negedge i_clk_sys);
		`CHK({o_bus_hold_grant_n, o_strobe_oe}, 2'b00)
		u_board.set_hold(1'b0);
		repeat (4) @(negedge i_clk_sys);
		`CHK({o_bus_hold_grant_n, o_strobe_oe}, 2'b11)
		// Hold granted while reset is held low; reset left low
		u_board.set_reset(1'b0);
		u_board.set_hold(1'b1);
		repeat (4) @(negedge i_clk_sys);
		`CHK({o_bus_hold_grant_n, o_strobe_oe, o_data_oe}, 3'b000)
		u_board.set_hold(1'b0);
		repeat (4) @(negedge i_clk_sys);
		`CHK({o_bus_hold_grant_n, o_strobe_oe, o_data_oe}, 3'b110)
	endtask

	// HALT left by a falling edge on the non-maskable interrupt pin
	task automatic t_nmi;
		int n;
		@(negedge i_clk_sys);
		i_stby_sel = SCRC_SEL_HALT;
		i_halt_exec = 1'b1;
		@(negedge i_clk_sys);
		i_halt_exec = 1'b0;
		i_nmi_pin = 1'b0;
		n = 0;
		while (o_cpu_clk_en !== 1'b1 && n < 20) begin
			@(negedge i_clk_sys);
			n++;
		end
		`CHK(n <= 5, 1'b1)
		i_nmi_pin = 1'b1;
	endtask

	initial begin
		i_ce = 1'b1;
		i_clk_src = SCRC_SRC_PLL_RES;
		{i_stby_sel, i_halt_exec, i_system_clock_out_pin_inhibit, i_int_req} = 5'h00;
		{i_nmi_pin, i_cpu_data_oe, i_cbr_refresh, i_watchdog_timeout_out} = 4'hC;
		i_cpu_addr = 24'h00ABCD;
		i_cpu_pc = 24'h123456;
		i_cpu_dout = 16'h5A5A;
		{i_port_out, i_port_oe} = 20'hFFFFF;
		i_chip_select_lines = 4'hF;
		{i_memory_read_strobe, i_io_read_strobe, i_io_write_strobe} = 3'h7;
		i_refresh_request_out = 1'b1;
		{i_lower_column_strobe, i_upper_column_strobe} = 2'h3;
		miscompares = 0;
		checked = 0;
		wait (i_rstn === 1'b1);
		for (int s = 0; s < 3; s++) begin
			t_fetch(s[1:0]);
			for (int m = 0; m < 3; m++)
				t_mode(m[1:0]);
		end
		t_hold();
		t_fetch(SCRC_SRC_PLL_RES);
		t_nmi();
		// Reset taken while parked in STOP
		@(negedge i_clk_sys);
		{i_stby_sel, i_halt_exec} = {SCRC_SEL_STOP, 1'b1};
		@(negedge i_clk_sys);
		i_halt_exec = 1'b0;
		t_fetch(SCRC_SRC_PLL_RES);
		final_report();
	end

	// Whole run is well under a thousand cycles
	initial begin
		repeat (5000) @(posedge i_clk_sys);
		miscompares++;
		final_report();
	end
endmodule // test_standby_clock_reset_control
